// ---- tb.sv ----
// self-checking bench for the timer pin block
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import tmx_pkg::*;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic [ADDR_W-1:0] addr = 8'h00;
  logic [15:0]       wdata = 16'h0000;
  logic              wr = 1'b0;
  logic              rd = 1'b0;
  logic [15:0]       rdata;
  logic [7:0]        p1;
  logic [7:0]        p3;
  logic              clk_pin;
  logic              clk_oe;
  int                err_total = 0;
  int                n_compared = 0;
  tmx_timer_pins tmx_timer_pins_inst (.i_core_clk(clk), .i_rst_n(rst_n),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd),
    .o_reg_rdata(rdata), .i_port1_pin(p1), .i_port3_pin(p3),
    .o_port1_bit_zero(clk_pin), .o_port1_bit_zero_oe(clk_oe));
  tmx_pin_src tmx_pin_src_inst (.i_core_clk(clk), .i_dev_clk(clk_pin),
    .i_dev_clk_oe(clk_oe), .o_port1(p1), .o_port3(p3));
  initial forever #10 clk = ~clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [15:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rd_reg
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] v;
    rd_reg(a, v);
    chk(v, e);
  endtask : rd_chk
  task automatic t_reset;
    for (int a = 0; a < 8; a++)
      // status shows direction up and the idle-high trigger level
      rd_chk(8'(a), (a == REG_STATUS) ? 16'h0018 : 16'h0000);
    chk({15'h0, clk_oe}, 16'h0000);
    $display("test reset done");
  endtask : t_reset
  task automatic t_count;
    wr_reg(REG_CTRL, 16'h000f);
    tmx_pin_src_inst.pulse(11, 2);
    tmx_pin_src_inst.pulse(8 + P3_T0_BIT, 5);
    tmx_pin_src_inst.pulse(8 + P3_T1_BIT, 3);
    repeat (4) @(posedge clk);
    rd_chk(REG_T0, 16'h0005);
    rd_chk(REG_T1, 16'h0003);
    wr_reg(REG_T0, 16'h0000);
    wr_reg(REG_CTRL, 16'h0004);
    wr_reg(REG_CTRL, 16'h0000);
    rd_chk(REG_T0, 16'h0002);
    $display("test count done");
  endtask : t_count
  task automatic t_capture;
    logic [15:0] s;
    wr_reg(REG_CTRL, 16'h0090);
    tmx_pin_src_inst.pulse(P1_CLK_BIT, 4);
    tmx_pin_src_inst.pulse(P1_TRIG_BIT, 1);
    repeat (4) @(posedge clk);
    rd_chk(REG_T2, 16'h0004);
    rd_chk(REG_CAPTURE, 16'h0004);
    rd_reg(REG_STATUS, s);
    chk(s & 16'h0001, 16'h0001);
    $display("test capture done");
  endtask : t_capture
  task automatic t_reload;
    logic [15:0] s;
    wr_reg(REG_CTRL, 16'h00a0);
    wr_reg(REG_RELOAD, 16'habcd);
    wr_reg(REG_T2, 16'h1234);
    tmx_pin_src_inst.pulse(P1_TRIG_BIT, 1);
    repeat (4) @(posedge clk);
    rd_chk(REG_T2, 16'habcd);
    rd_reg(REG_STATUS, s);
    chk(s & 16'h0002, 16'h0002);
    $display("test reload done");
  endtask : t_reload
  task automatic t_updown;
    logic [15:0] s;
    wr_reg(REG_CTRL, 16'h00c0);
    for (int v = 0; v < 2; v++)
    begin
      tmx_pin_src_inst.level(P1_TRIG_BIT, v[0]);
      repeat (5) @(posedge clk);
      rd_reg(REG_STATUS, s);
      chk(s & 16'h0008, v ? 16'h0008 : 16'h0000);
      wr_reg(REG_T2, 16'h0100);
      wr_reg(REG_CTRL, 16'h00d0);
      wr_reg(REG_CTRL, 16'h00c0);
      rd_chk(REG_T2, v ? 16'h0102 : 16'h00fe);
    end
    $display("test updown done");
  endtask : t_updown
  task automatic t_clkout;
    int          n;
    logic        last;
    logic [15:0] s;
    wr_reg(REG_RELOAD, 16'hfffe);
    wr_reg(REG_T2, 16'hfffe);
    wr_reg(REG_CTRL, 16'h0070);
    #1 chk({15'h0, clk_oe}, 16'h0001);
    n = 0;
    last = clk_pin;
    repeat (16)
    begin
      @(posedge clk);
      #1 n += int'(clk_pin !== last);
      last = clk_pin;
    end
    chk(16'(n), 16'h0008);
    rd_reg(REG_STATUS, s);
    chk(s & 16'h0004, 16'h0004);
    wr_reg(REG_CTRL, 16'h0000);
    #1 chk({15'h0, clk_oe}, 16'h0000);
    $display("test clkout done");
  endtask : t_clkout
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_count;
    t_capture;
    t_reload;
    t_updown;
    t_clkout;
    wrap_up;
  end
  // the tests take about 200 cycles; this bound only cuts a hang
  initial
  begin
    #100us;
    err_total++;
    wrap_up;
  end
endmodule : tb

// ---- tmx_pin_src.sv ----
// external count, clock and trigger sources behind pulled-up port pins
module tmx_pin_src (
  // clock
  input  wire logic       i_core_clk,
  // device drive of the clock pin
  input  wire logic       i_dev_clk,
  input  wire logic       i_dev_clk_oe,
  // levels seen on the pins
  output logic      [7:0] o_port1,
  output logic      [7:0] o_port3
);
  timeunit 1ns;
  timeprecision 1ns;
  // port 1 in bits 7:0, port 3 in bits 15:8; released pins pull high
  logic [15:0] pins = 16'hffff;
  // wire level of the shared clock pin
  assign o_port1 = {pins[7:1], i_dev_clk_oe ? i_dev_clk : pins[0]};
  assign o_port3 = pins[15:8];
  // two clocks low then two high, so no fall is missed
  task automatic pulse(input int b, input int n);
    repeat (n)
    begin
      @(posedge i_core_clk);
      pins[b] <= 1'b0;
      repeat (2) @(posedge i_core_clk);
      pins[b] <= 1'b1;
      repeat (2) @(posedge i_core_clk);
    end
  endtask : pulse
  task automatic level(input int b, input logic v);
    @(posedge i_core_clk);
    pins[b] <= v;
  endtask : level
endmodule : tmx_pin_src

// ---- tmx_properties.sv ----
// port checker for the timer pin block
module tmx_properties
  import tmx_pkg::*;
#(
  parameter int CNT_W  = 16,
  parameter int DATA_W = 16
)(
  // clock and reset
  input wire logic              i_core_clk,
  input wire logic              i_rst_n,
  // register port
  input wire logic [ADDR_W-1:0] i_reg_addr,
  input wire logic [DATA_W-1:0] i_reg_wdata,
  input wire logic              i_reg_wr,
  input wire logic              i_reg_rd,
  input wire logic [DATA_W-1:0] o_reg_rdata,
  // pins
  input wire logic [7:0]        i_port1_pin,
  input wire logic [7:0]        i_port3_pin,
  input wire logic              o_port1_bit_zero,
  input wire logic              o_port1_bit_zero_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [CTRL_W-1:0] ctrl_sh;
  logic [1:0]        mode_sh;
  logic [4:0]        trig_hist;
  logic              trig_quiet;
  // shadow of control, since mode is not visible at the ports
  always_ff @(posedge i_core_clk or negedge i_rst_n)
    if (!i_rst_n)
      ctrl_sh <= CTRL_RST;
    else if (i_reg_wr && i_reg_addr == REG_CTRL)
      ctrl_sh <= i_reg_wdata[CTRL_W-1:0];
  // five quiet samples cover the synchroniser and a status flop
  always_ff @(posedge i_core_clk or negedge i_rst_n)
    if (!i_rst_n)
      trig_hist <= 5'h1f;
    else
      trig_hist <= {trig_hist[3:0], i_port1_pin[P1_TRIG_BIT]};
  assign mode_sh    = ctrl_sh[CTRL_MODE_HI:CTRL_MODE_LO];
  assign trig_quiet = trig_hist == {5{i_port1_pin[P1_TRIG_BIT]}};
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_ctrl_rd;
    i_reg_rd && i_reg_addr == REG_CTRL;
  endsequence
  sequence s_stat_rd;
    i_reg_rd && i_reg_addr == REG_STATUS && trig_quiet;
  endsequence
  a_oe_clkout: assert property (
    mode_sh == T2_CLKOUT |-> o_port1_bit_zero_oe) else $error("no drive");
  a_oe_capture: assert property (
    mode_sh == T2_CAPTURE |-> !o_port1_bit_zero_oe) else $error("drives");
  a_pin_quiet: assert property (
    !o_port1_bit_zero_oe [*2] |-> $stable(o_port1_bit_zero))
    else $error("pin moved undriven");
  a_pin_source: assert property (
    $changed(o_port1_bit_zero) |-> $past(o_port1_bit_zero_oe))
    else $error("pin toggled outside clock-out");
  a_rdata_zero: assert property (
    !i_reg_rd |=> o_reg_rdata == '0) else $error("stray read data");
  a_ctrl_back: assert property (
    s_ctrl_rd |=> o_reg_rdata[CTRL_W-1:0] == ctrl_sh)
    else $error("control readback");
  a_trig_level: assert property (
    s_stat_rd |=> o_reg_rdata[ST_TRIG] == $past(i_port1_pin[P1_TRIG_BIT]))
    else $error("trigger level");
  a_dir_level: assert property (
    s_stat_rd and mode_sh == T2_UPDOWN
    |=> o_reg_rdata[ST_DIR] == $past(i_port1_pin[P1_TRIG_BIT]))
    else $error("direction");
endmodule : tmx_properties

bind tmx_timer_pins tmx_properties #(.CNT_W(CNT_W), .DATA_W(DATA_W))
  tmx_properties_inst (.i_core_clk, .i_rst_n, .i_reg_addr, .i_reg_wdata,
  .i_reg_wr, .i_reg_rd, .o_reg_rdata, .i_port1_pin, .i_port3_pin,
  .o_port1_bit_zero, .o_port1_bit_zero_oe);

// ---- tmx_sync_edge.sv ----
// constants package and two-flop input synchroniser with falling-edge detect
package tmx_pkg;
  // register map (word offsets on the plain register port)
  localparam int          ADDR_W      = 8;
  localparam logic [7:0]  REG_CTRL    = 8'h00;
  localparam logic [7:0]  REG_T0      = 8'h01;
  localparam logic [7:0]  REG_T1      = 8'h02;
  localparam logic [7:0]  REG_T2      = 8'h03;
  localparam logic [7:0]  REG_RELOAD  = 8'h04;
  localparam logic [7:0]  REG_CAPTURE = 8'h05;
  localparam logic [7:0]  REG_STATUS  = 8'h06;
  // control field positions
  localparam int          CTRL_T0_CNT = 0;
  localparam int          CTRL_T1_CNT = 1;
  localparam int          CTRL_T0_RUN = 2;
  localparam int          CTRL_T1_RUN = 3;
  localparam int          CTRL_T2_RUN = 4;
  localparam int          CTRL_MODE_LO = 5;
  localparam int          CTRL_MODE_HI = 6;
  localparam int          CTRL_TRIG_EN = 7;
  localparam int          CTRL_W      = 8;
  localparam logic [7:0]  CTRL_RST    = 8'h00;
  // status field positions
  localparam int          ST_CAPT     = 0;
  localparam int          ST_RELD     = 1;
  localparam int          ST_OVF      = 2;
  localparam int          ST_DIR      = 3;
  localparam int          ST_TRIG     = 4;
  localparam int          ST_FLAGS    = 3;
  localparam logic [2:0]  FLAGS_RST   = 3'h0;
  // pin positions on the shared ports
  localparam int          P3_T0_BIT   = 4;
  localparam int          P3_T1_BIT   = 5;
  localparam int          P1_CLK_BIT  = 0;
  localparam int          P1_TRIG_BIT = 1;
  // index into the synchronised input vector
  localparam int          SY_T0       = 0;
  localparam int          SY_T1       = 1;
  localparam int          SY_CLK      = 2;
  localparam int          SY_TRIG     = 3;
  localparam int          SY_W        = 4;
  localparam logic        PIN_RST     = 1'b1;
  typedef enum logic [1:0] {
    T2_CAPTURE = 2'h0,
    T2_RELOAD  = 2'h1,
    T2_UPDOWN  = 2'h2,
    T2_CLKOUT  = 2'h3
  } tmx_t2_mode_t;
endpackage : tmx_pkg

module tmx_sync_edge
  import tmx_pkg::*;
#(
  parameter int WIDTH = 4
)(
  // clock and reset
  input  wire logic             i_core_clk,
  input  wire logic             i_rst_n,
  // raw pins
  input  wire logic [WIDTH-1:0] i_async,
  // synchronised level and falling-edge pulse
  output logic      [WIDTH-1:0] o_level,
  output logic      [WIDTH-1:0] o_fall
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] sync;
  logic [WIDTH-1:0] prev;

  initial
  begin
    if (WIDTH < 1) $error("tmx_sync_edge: WIDTH must be at least 1");
  end

  // two-flop sync
  // pins idle high, so reset to high avoids a false edge after release
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      meta <= '1;
      sync <= '1;
      prev <= '1;
    end
    else
    begin
      meta <= i_async;
      sync <= meta;
      prev <= sync;
    end
  end

  assign o_level = sync;
  assign o_fall  = prev & ~sync;
endmodule : tmx_sync_edge

// ---- tmx_timer_pins.sv ----
// timer external pin logic: counters 0/1, timer 2 clock pin and trigger
//
// The address map and the plain strobed port were left to the implementer.
module tmx_timer_pins
  import tmx_pkg::*;
#(
  parameter int CNT_W  = 16,
  parameter int DATA_W = 16
)(
  // clock and reset
  input  wire logic              i_core_clk,
  input  wire logic              i_rst_n,
  // register port
  input  wire logic [ADDR_W-1:0] i_reg_addr,
  input  wire logic [DATA_W-1:0] i_reg_wdata,
  input  wire logic              i_reg_wr,
  input  wire logic              i_reg_rd,
  output logic      [DATA_W-1:0] o_reg_rdata,
  // shared port pins in
  input  wire logic [7:0]        i_port1_pin,
  input  wire logic [7:0]        i_port3_pin,
  // timer 2 clock pin drive
  output logic                   o_port1_bit_zero,
  output logic                   o_port1_bit_zero_oe
);
  logic [SY_W-1:0]          raw_in;
  logic [SY_W-1:0]          lvl;
  logic [SY_W-1:0]          fall;
  logic [CTRL_W-1:0]        ctrl;
  logic [1:0][CNT_W-1:0]    t01_q;
  logic [CNT_W-1:0]         t2_count;
  logic [CNT_W-1:0]         reload_val;
  logic [CNT_W-1:0]         capture_val;
  logic [ST_FLAGS-1:0]      flags;
  logic                     pin_q;
  tmx_t2_mode_t             mode;
  logic                     t2_run;
  logic                     trig_en;
  logic                     t2_tick;
  logic                     count_up;
  logic                     t2_ovf;
  logic                     trig_capture;
  logic                     trig_reload;
  logic [CNT_W-1:0]         next_t2_count;
  logic [ST_FLAGS-1:0]      flag_set;
  logic [ST_FLAGS-1:0]      flag_clr;
  logic [DATA_W-1:0]        next_rdata;

  initial
  begin
    if (CNT_W < 2) $error("tmx_timer_pins: CNT_W must be at least 2");
    if (DATA_W < CNT_W) $error("tmx_timer_pins: DATA_W below CNT_W");
    if (DATA_W < CTRL_W) $error("tmx_timer_pins: DATA_W below CTRL_W");
  end

  assign raw_in[SY_T0]   = i_port3_pin[P3_T0_BIT];
  assign raw_in[SY_T1]   = i_port3_pin[P3_T1_BIT];
  assign raw_in[SY_CLK]  = i_port1_pin[P1_CLK_BIT];
  assign raw_in[SY_TRIG] = i_port1_pin[P1_TRIG_BIT];

  tmx_sync_edge #(
    .WIDTH      (SY_W)
  ) u_sync (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_async    (raw_in),
    .o_level    (lvl),
    .o_fall     (fall)
  );

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      ctrl <= CTRL_RST;
    else if (i_reg_wr && i_reg_addr == REG_CTRL)
      ctrl <= i_reg_wdata[CTRL_W-1:0];
  end

  assign mode    = tmx_t2_mode_t'(ctrl[CTRL_MODE_HI:CTRL_MODE_LO]);
  assign t2_run  = ctrl[CTRL_T2_RUN];
  assign trig_en = ctrl[CTRL_TRIG_EN];

  // timers 0 and 1: counter mode counts pin falls, timer mode every cycle
  for (genvar g = 0; g < 2; g++)
  begin : g_t01
    logic [CNT_W-1:0] count;
    logic             hit;
    logic             tick;
    assign hit  = i_reg_wr && i_reg_addr == (g == 0 ? REG_T0 : REG_T1);
    assign tick = ctrl[CTRL_T0_RUN + g] &&
                  (!ctrl[CTRL_T0_CNT + g] || fall[SY_T0 + g]);
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
      if (!i_rst_n)
        count <= '0;
      else if (hit)
        count <= i_reg_wdata[CNT_W-1:0];
      else if (tick)
        count <= count + 1'b1;
    end
    assign t01_q[g] = count;
  end

  assign t2_tick  = t2_run && (mode != T2_CAPTURE || fall[SY_CLK]);
  assign count_up = (mode != T2_UPDOWN) || lvl[SY_TRIG];
  assign t2_ovf   = t2_tick &&
                    (count_up ? (t2_count == '1) : (t2_count == reload_val));
  assign trig_capture = trig_en && mode == T2_CAPTURE && fall[SY_TRIG];
  assign trig_reload  = trig_en && mode == T2_RELOAD && fall[SY_TRIG];

  always_comb
  begin
    next_t2_count = t2_count;
    if (i_reg_wr && i_reg_addr == REG_T2)
      next_t2_count = i_reg_wdata[CNT_W-1:0];
    else if (trig_reload)
      next_t2_count = reload_val;
    else if (t2_ovf)
    begin
      // capture mode wraps freely; down-count underflow restarts at top
      if (mode == T2_CAPTURE)
        next_t2_count = '0;
      else if (count_up)
        next_t2_count = reload_val;
      else
        next_t2_count = '1;
    end
    else if (t2_tick)
      next_t2_count = count_up ? t2_count + 1'b1 : t2_count - 1'b1;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      t2_count <= '0;
    else
      t2_count <= next_t2_count;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      reload_val <= '0;
    else if (i_reg_wr && i_reg_addr == REG_RELOAD)
      reload_val <= i_reg_wdata[CNT_W-1:0];
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      capture_val <= '0;
    else if (trig_capture)
      capture_val <= t2_count;
  end

  // clock-out toggles per overflow
  // output frequency is the overflow rate halved; pin idles high
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      pin_q <= PIN_RST;
    else if (mode == T2_CLKOUT && t2_ovf)
      pin_q <= ~pin_q;
  end

  assign o_port1_bit_zero    = pin_q;
  assign o_port1_bit_zero_oe = (mode == T2_CLKOUT);

  // sticky event flags, write one to clear; a new event beats the clear
  assign flag_set[ST_CAPT] = trig_capture;
  assign flag_set[ST_RELD] = trig_reload;
  assign flag_set[ST_OVF]  = t2_ovf;
  assign flag_clr = (i_reg_wr && i_reg_addr == REG_STATUS) ?
                    i_reg_wdata[ST_FLAGS-1:0] : '0;

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      flags <= FLAGS_RST;
    else
      flags <= (flags & ~flag_clr) | flag_set;
  end

  always_comb
  begin
    next_rdata = '0;
    if (i_reg_rd)
    begin
      case (i_reg_addr)
        REG_CTRL:    next_rdata[CTRL_W-1:0] = ctrl;
        REG_T0:      next_rdata[CNT_W-1:0]  = t01_q[0];
        REG_T1:      next_rdata[CNT_W-1:0]  = t01_q[1];
        REG_T2:      next_rdata[CNT_W-1:0]  = t2_count;
        REG_RELOAD:  next_rdata[CNT_W-1:0]  = reload_val;
        REG_CAPTURE: next_rdata[CNT_W-1:0]  = capture_val;
        REG_STATUS:
        begin
          next_rdata[ST_FLAGS-1:0] = flags;
          next_rdata[ST_DIR]       = count_up;
          next_rdata[ST_TRIG]      = lvl[SY_TRIG];
        end
        default:     next_rdata = '0;
      endcase
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_reg_rdata <= '0;
    else
      o_reg_rdata <= next_rdata;
  end
endmodule : tmx_timer_pins
